// ---- src/acs_defs.vh ----
// Register map, field positions, reset values and timing counts of the sequencer
`ifndef ACS_DEFS_VH
`define ACS_DEFS_VH

// Register offsets, one 16-bit register per address
`define ACS_OFF_CTRLA 4'h0
`define ACS_OFF_CTRLB 4'h1
`define ACS_OFF_CTRLC 4'h2
`define ACS_OFF_CTRLD 4'h3
`define ACS_OFF_SAMPCTRL 4'h4
`define ACS_OFF_MUX 4'h5
`define ACS_OFF_COMMAND 4'h6
`define ACS_OFF_EVCTRL 4'h7
`define ACS_OFF_INTCTRL 4'h8
`define ACS_OFF_INTFLAGS 4'h9
`define ACS_OFF_RES 4'ha

// Control A bit positions
`define ACS_BIT_ENABLE 0
`define ACS_BIT_CONTINUOUS_RUN_EN 1
`define ACS_BIT_LEFTALIGN 2
`define ACS_BIT_RES10 3
`define ACS_BIT_DIFF 4

// Field widths and positions
`define ACS_ACCSEL_W 3
`define ACS_DIVSEL_W 3
`define ACS_WARMUP_LSB 0
`define ACS_WARMUP_W 8
`define ACS_SDLY_LSB 8
`define ACS_SDLY_W 4
`define ACS_SLEN_W 8
`define ACS_MUX_W 7
`define ACS_NEG_LSB 8

// Reset values
`define ACS_RST_CTRLA 5'h00
`define ACS_RST_CTRLB 3'h0
`define ACS_RST_CTRLC 3'h0
`define ACS_RST_CTRLD 12'h000
`define ACS_RST_SAMPCTRL 8'h00
`define ACS_RST_MUX 7'h00

// Timing counts: peripheral cycles, converter cycles (sample-hold base) and converter half cycles
`define ACS_STARTUP_CYC 2'h1
`define ACS_FORMAT_CYC 2'h2
`define ACS_SH_BASE_CYC 10'h002
`define ACS_CONV_HALF 10'h01b

`endif

// ---- src/acs_prescaler.v ----
// Converter clock prescaler, held in reset while no conversion runs
module acs_prescaler #(
  parameter DIV_W = 3
) (
  input wire clock,
  input wire nrst,
  input wire run,
  input wire [DIV_W-1:0] divsel,
  output wire half_tick,
  output reg conv_clk_r
);

  reg [7:0] cnt_r;
  wire [8:0] half_len;

  // Half period is 2^divsel peripheral cycles, full period twice that
  assign half_len = 9'h001 << divsel;
  assign half_tick = run && ({1'b0, cnt_r} == half_len - 9'h001);

  // Count restarts from zero each time run rises
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 8'h00;
      conv_clk_r <= 1'b0;
    end else if (!run) begin
      cnt_r <= 8'h00;
      conv_clk_r <= 1'b0;
    end else if (half_tick) begin
      cnt_r <= 8'h00;
      conv_clk_r <= ~conv_clk_r;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

endmodule // acs_prescaler

// ---- src/acs_sequencer.v ----
// Conversion sequencer for a successive-approximation converter
//
// How it works
// - Command write starts; bit reads busy, self-clears
// - Channel latched at start, changes apply later
// - Completion sets ready flag, gated interrupt request
// - Ready flag sets regardless of interrupt enable
// - Enabled event starts conversion, sets command bit
// - Only rising event edge starts a conversion
// - Free-run restarts right after each completion
// - Prescaler held in reset while idle
// - Conversion begins one cycle after trigger
// - Startup, sample-hold, 13.5 cycle convert, format
// - Accumulator cleared when new accumulation starts
// - Accumulate selected count back to back, 12-bit
// - Ready flag each free-run result, with accumulation
// - Ten or twelve bit result per resolution; accumulation always uses twelve-bit samples
// - Warm-up delay in converter cycles after enable
// - Differential bit selects single-ended or differential
// - Differential results sign extended, single unsigned
// - Sampling lasts two plus delay plus length
`include "acs_defs.vh"

module acs_sequencer #(
  parameter ADDR_W = 4,
  parameter DATA_W = 16,
  parameter RAW_W = 12
) (
  input wire clock,
  input wire nrst,
  input wire [ADDR_W-1:0] addr,
  input wire [DATA_W-1:0] wdata,
  input wire wr,
  input wire rd,
  output reg [DATA_W-1:0] rdata_r,
  input wire start_event,
  input wire global_int_en,
  output wire irq,
  output reg result_ready_event_r,
  output wire [`ACS_MUX_W-1:0] positive_input_select,
  output wire [`ACS_MUX_W-1:0] negative_input_select,
  output wire core_differential,
  output wire core_clk,
  output wire core_sample,
  output wire core_convert,
  input wire [RAW_W-1:0] core_result
);

  localparam ST_IDLE = 3'h0;
  localparam ST_STARTUP = 3'h1;
  localparam ST_WARMUP = 3'h2;
  localparam ST_SAMPLE = 3'h3;
  localparam ST_CONVERT = 3'h4;
  localparam ST_FORMAT = 3'h5;

  ////////////////////////////////////////////////////////////////////////
  // Software registers

  reg [4:0] ctrla_r;
  reg [`ACS_ACCSEL_W-1:0] accumulate_count_select_r;
  reg [`ACS_DIVSEL_W-1:0] converter_clock_divider_r;
  reg [11:0] ctrld_r;
  reg [`ACS_SLEN_W-1:0] sample_length_cycles_r;
  reg [`ACS_MUX_W-1:0] pos_sel_r;
  reg [`ACS_MUX_W-1:0] neg_sel_r;
  reg start_event_input_en_r;
  reg ready_int_en_r;
  reg result_ready_flag_r;
  reg [DATA_W-1:0] result_r;

  wire enable = ctrla_r[`ACS_BIT_ENABLE];
  wire continuous_run_en = ctrla_r[`ACS_BIT_CONTINUOUS_RUN_EN];
  wire result_left_align = ctrla_r[`ACS_BIT_LEFTALIGN];
  wire resolution_select = ctrla_r[`ACS_BIT_RES10];
  wire differential_select = ctrla_r[`ACS_BIT_DIFF];
  wire [`ACS_WARMUP_W-1:0] warmup_delay_cycles =
    ctrld_r[`ACS_WARMUP_LSB +: `ACS_WARMUP_W];
  wire [`ACS_SDLY_W-1:0] sample_delay_cycles =
    ctrld_r[`ACS_SDLY_LSB +: `ACS_SDLY_W];

  // Sequencer state
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [9:0] cnt_r;
  reg [1:0] pcnt_r;
  reg [7:0] sample_idx_r;
  reg [19:0] acc_r;
  reg start_conversion_cmd_r;
  reg warm_done_r;
  reg event_prev_r;
  reg [`ACS_MUX_W-1:0] act_pos_r;
  reg [`ACS_MUX_W-1:0] act_neg_r;
  reg act_diff_r;

  wire half_tick;
  wire conv_clk;

  // Decode used by the write path; the read path decodes with a case
  function sel;
    input [ADDR_W-1:0] a;
    input [3:0] off;
    begin
      sel = (a == off);
    end
  endfunction

  // Fold the accumulated sum into the 16-bit result register.
  // Sums wider than 16 bits lose their low bits to avoid overflow.
  function [15:0] fmt_result;
    input [19:0] acc;
    input [2:0] n;
    input r10;
    input dif;
    input left;
    reg [4:0] w;
    reg [19:0] v;
    begin
      w = (r10 && n == 3'h0) ? 5'h0a : 5'h0c + {2'b00, n};
      v = acc;
      if (w > 5'h10) begin
        if (dif)
          v = $signed(acc) >>> (w - 5'h10);
        else
          v = acc >> (w - 5'h10);
        w = 5'h10;
      end
      if (left)
        fmt_result = v[15:0] << (5'h10 - w);
      else
        fmt_result = v[15:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Trigger detection

  wire event_rise = start_event && !event_prev_r;
  wire cmd_write = wr && sel(addr, `ACS_OFF_COMMAND) && wdata[0];
  // Starts are taken only from idle; a start while busy is dropped
  wire trigger = enable && (state_r == ST_IDLE) &&
    (cmd_write || (start_event_input_en_r && event_rise));

  wire [9:0] sample_half = (`ACS_SH_BASE_CYC +
    {6'h00, sample_delay_cycles} + {2'b00, sample_length_cycles_r}) << 1;
  wire [9:0] warm_half = {1'b0, warmup_delay_cycles, 1'b0};
  wire [7:0] last_idx = (8'h01 << accumulate_count_select_r) - 8'h01;
  wire last_sample = (sample_idx_r == last_idx);
  wire free_again = enable && continuous_run_en;

  // Sample from the core, widened; ten-bit only outside accumulation
  wire narrow = resolution_select && (accumulate_count_select_r == 3'h0);
  reg [19:0] raw_ext;
  always @* begin
    raw_ext = {8'h00, core_result};
    if (act_diff_r && narrow)
      raw_ext = {{10{core_result[11]}}, core_result[11:2]};
    else if (narrow)
      raw_ext = {10'h000, core_result[11:2]};
    else if (act_diff_r)
      raw_ext = {{8{core_result[11]}}, core_result};
  end
  wire [19:0] acc_sum = acc_r + raw_ext;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer next state

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (trigger)
          state_nxt = ST_STARTUP;
      end
      ST_STARTUP: begin
        if (pcnt_r == `ACS_STARTUP_CYC - 2'h1)
          state_nxt = (warm_done_r || ~|warm_half) ? ST_SAMPLE : ST_WARMUP;
      end
      ST_WARMUP: begin
        if (half_tick && cnt_r == warm_half - 10'h001)
          state_nxt = ST_SAMPLE;
      end
      ST_SAMPLE: begin
        if (half_tick && cnt_r == sample_half - 10'h001)
          state_nxt = ST_CONVERT;
      end
      ST_CONVERT: begin
        if (half_tick && cnt_r == `ACS_CONV_HALF - 10'h001)
          state_nxt = ST_FORMAT;
      end
      ST_FORMAT: begin
        if (pcnt_r == `ACS_FORMAT_CYC - 2'h1) begin
          if (!last_sample)
            state_nxt = ST_SAMPLE;
          else if (free_again)
            state_nxt = ST_SAMPLE;
          else
            state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (!enable)
      state_nxt = ST_IDLE;
  end

  wire phase_change = (state_nxt != state_r);
  wire done = (state_r == ST_FORMAT) &&
    (pcnt_r == `ACS_FORMAT_CYC - 2'h1) && last_sample;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer registers

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      cnt_r <= 10'h000;
      pcnt_r <= 2'h0;
      sample_idx_r <= 8'h00;
      acc_r <= 20'h00000;
      start_conversion_cmd_r <= 1'b0;
      warm_done_r <= 1'b0;
      event_prev_r <= 1'b0;
      act_pos_r <= `ACS_RST_MUX;
      act_neg_r <= `ACS_RST_MUX;
      act_diff_r <= 1'b0;
      result_r <= 16'h0000;
      result_ready_event_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      event_prev_r <= start_event;
      result_ready_event_r <= done && enable;
      // Half-tick counter per phase, cycle counter for fixed phases
      if (phase_change) begin
        cnt_r <= 10'h000;
        pcnt_r <= 2'h0;
      end else begin
        pcnt_r <= pcnt_r + 2'h1;
        if (half_tick)
          cnt_r <= cnt_r + 10'h001;
      end
      if (!enable)
        warm_done_r <= 1'b0;
      else if (state_r == ST_WARMUP && state_nxt == ST_SAMPLE)
        warm_done_r <= 1'b1;
      // Latch channel and mode at each new trigger and at each free-run restart
      if (trigger || (done && free_again)) begin
        act_pos_r <= pos_sel_r;
        act_neg_r <= neg_sel_r;
        act_diff_r <= differential_select;
        acc_r <= 20'h00000;
        sample_idx_r <= 8'h00;
      end else if (state_r == ST_FORMAT && pcnt_r == 2'h0) begin
        acc_r <= acc_sum;
      end else if (state_r == ST_FORMAT && phase_change && !last_sample) begin
        sample_idx_r <= sample_idx_r + 8'h01;
      end
      if (done)
        result_r <= fmt_result(acc_r, accumulate_count_select_r,
          resolution_select, act_diff_r, result_left_align);
      // Busy bit covers the whole sequence, free-run included
      if (!enable)
        start_conversion_cmd_r <= 1'b0;
      else if (trigger)
        start_conversion_cmd_r <= 1'b1;
      else if (done && !free_again)
        start_conversion_cmd_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Converter clock

  wire converter_clock_divider_run = (state_r == ST_WARMUP) || (state_r == ST_SAMPLE) ||
    (state_r == ST_CONVERT);

  acs_prescaler #(
    .DIV_W(`ACS_DIVSEL_W)
  ) u_converter_clock_divider (
    .clock(clock),
    .nrst(nrst),
    .run(converter_clock_divider_run),
    .divsel(converter_clock_divider_r),
    .half_tick(half_tick),
    .conv_clk_r(conv_clk)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register writes

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrla_r <= `ACS_RST_CTRLA;
      accumulate_count_select_r <= `ACS_RST_CTRLB;
      converter_clock_divider_r <= `ACS_RST_CTRLC;
      ctrld_r <= `ACS_RST_CTRLD;
      sample_length_cycles_r <= `ACS_RST_SAMPCTRL;
      pos_sel_r <= `ACS_RST_MUX;
      neg_sel_r <= `ACS_RST_MUX;
      start_event_input_en_r <= 1'b0;
      ready_int_en_r <= 1'b0;
      result_ready_flag_r <= 1'b0;
    end else begin
      if (wr && sel(addr, `ACS_OFF_CTRLA))
        ctrla_r <= wdata[4:0];
      if (wr && sel(addr, `ACS_OFF_CTRLB))
        accumulate_count_select_r <= wdata[`ACS_ACCSEL_W-1:0];
      if (wr && sel(addr, `ACS_OFF_CTRLC))
        converter_clock_divider_r <= wdata[`ACS_DIVSEL_W-1:0];
      if (wr && sel(addr, `ACS_OFF_CTRLD))
        ctrld_r <= wdata[11:0];
      if (wr && sel(addr, `ACS_OFF_SAMPCTRL))
        sample_length_cycles_r <= wdata[`ACS_SLEN_W-1:0];
      if (wr && sel(addr, `ACS_OFF_MUX)) begin
        pos_sel_r <= wdata[`ACS_MUX_W-1:0];
        neg_sel_r <= wdata[`ACS_NEG_LSB +: `ACS_MUX_W];
      end
      if (wr && sel(addr, `ACS_OFF_EVCTRL))
        start_event_input_en_r <= wdata[0];
      if (wr && sel(addr, `ACS_OFF_INTCTRL))
        ready_int_en_r <= wdata[0];
      // Completion wins over a same-cycle write-one-to-clear
      if (done)
        result_ready_flag_r <= 1'b1;
      else if (wr && sel(addr, `ACS_OFF_INTFLAGS) && wdata[0])
        result_ready_flag_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register reads, one cycle after the strobe; unmapped reads give zero

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 16'h0000;
    end else if (rd) begin
      case (addr)
        `ACS_OFF_CTRLA: rdata_r <= {11'h000, ctrla_r};
        `ACS_OFF_CTRLB: rdata_r <= {13'h0000, accumulate_count_select_r};
        `ACS_OFF_CTRLC: rdata_r <= {13'h0000, converter_clock_divider_r};
        `ACS_OFF_CTRLD: rdata_r <= {4'h0, ctrld_r};
        `ACS_OFF_SAMPCTRL: rdata_r <= {8'h00, sample_length_cycles_r};
        `ACS_OFF_MUX: rdata_r <= {1'b0, neg_sel_r, 1'b0, pos_sel_r};
        `ACS_OFF_COMMAND: rdata_r <= {15'h0000, start_conversion_cmd_r};
        `ACS_OFF_EVCTRL: rdata_r <= {15'h0000, start_event_input_en_r};
        `ACS_OFF_INTCTRL: rdata_r <= {15'h0000, ready_int_en_r};
        `ACS_OFF_INTFLAGS: rdata_r <= {15'h0000, result_ready_flag_r};
        `ACS_OFF_RES: rdata_r <= result_r;
        default: rdata_r <= 16'h0000;
      endcase
    end else begin
      rdata_r <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs to the analog core and the interrupt controller

  assign irq = result_ready_flag_r && ready_int_en_r && global_int_en;
  assign positive_input_select = act_pos_r;
  assign negative_input_select = act_neg_r;
  assign core_differential = act_diff_r;
  assign core_clk = conv_clk;
  assign core_sample = (state_r == ST_SAMPLE);
  assign core_convert = (state_r == ST_CONVERT);

endmodule // acs_sequencer

// ---- test/acs_checker.sv ----
// Concurrent checks on the sequencer ports
module acs_checker (
  input wire clock,
  input wire nrst,
  input wire rd,
  input wire [15:0] rdata_r,
  input wire global_int_en,
  input wire irq,
  input wire result_ready_event_r,
  input wire [6:0] positive_input_select,
  input wire core_differential,
  input wire core_sample,
  input wire core_convert
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  reg [5:0] conv_cnt_r;

  ////////////////////////////////////////////////////////////////////////
  // Length of the converting phase, saturating so slow clocks cannot wrap
  always @(posedge clock or negedge nrst) begin
    if (!nrst)
      conv_cnt_r <= 6'h00;
    else if (core_convert)
      conv_cnt_r <= conv_cnt_r + {5'h00, conv_cnt_r != 6'h3f};
    else
      conv_cnt_r <= 6'h00;
  end

  sequence s_hold;
    core_sample [*4];
  endsequence

  ////////////////////////////////////////////////////////////////////////
  // Phase order, lengths, result timing and bus behaviour
  a_sample_hold_min: assert property ($rose(core_sample) |-> s_hold)
    else $error("sampling phase shorter than four cycles");
  a_sample_then_conv: assert property ($rose(core_convert) |-> $past(core_sample))
    else $error("convert phase not preceded by sampling");
  a_phase_exclusive: assert property (!(core_sample && core_convert))
    else $error("sampling and converting at once");
  a_conv_length: assert property ($fell(core_convert) |-> conv_cnt_r >= 6'h1b)
    else $error("converting phase too short");
  a_ready_after_fmt: assert property (result_ready_event_r |-> $past(core_convert, 3)
    && !$past(core_convert, 2) && !$past(core_convert))
    else $error("ready pulse not two cycles after conversion");
  a_ready_one_pulse: assert property (result_ready_event_r |=> !result_ready_event_r)
    else $error("ready pulse longer than one cycle");
  a_irq_global_gate: assert property (irq |-> global_int_en)
    else $error("interrupt without global enable");
  a_rdata_idle_zero: assert property (!$past(rd) |-> rdata_r == 16'h0000)
    else $error("read data outside read answer cycle");
  a_channel_latched: assert property ((core_sample || core_convert)
    && $past(core_sample || core_convert) |-> $stable(positive_input_select)
    && $stable(core_differential))
    else $error("channel changed during a conversion");
endmodule // acs_checker

bind acs_sequencer acs_checker u_chk (.clock(clock), .nrst(nrst), .rd(rd),
  .rdata_r(rdata_r), .global_int_en(global_int_en), .irq(irq),
  .result_ready_event_r(result_ready_event_r),
  .positive_input_select(positive_input_select),
  .core_differential(core_differential), .core_sample(core_sample),
  .core_convert(core_convert));

// ---- test/acs_core_model.sv ----
// Behavioural analog core: returns a code derived from the latched channel
module acs_core_model (
  input wire clock,
  input wire nrst,
  input wire core_convert,
  input wire core_differential,
  input wire [6:0] positive_input_select,
  output reg [11:0] core_result
);
  timeunit 1ns;
  timeprecision 100ps;
  reg [1:0] hold_r;

  // Code stays valid three cycles after converting ends, then scrambles
  // so a late sample sees its complement, and the stale value again every other cycle
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      core_result <= 12'h000;
      hold_r <= 2'h0;
    end else if (core_convert) begin
      core_result <= core_differential ? {5'h10, positive_input_select}
        : {5'h01, positive_input_select};
      hold_r <= 2'h2;
    end else if (hold_r != 2'h0) begin
      hold_r <= hold_r - 2'h1;
    end else begin
      core_result <= ~core_result;
    end
  end
endmodule // acs_core_model

// ---- test/acs_sequencer_bench.sv ----
// Self-checking bench for the conversion sequencer
`include "acs_defs.vh"
module acs_sequencer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0;
  logic start_event = 1'b0, global_int_en = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  wire [15:0] rdata_r;
  wire irq, result_ready_event_r, core_differential, core_clk;
  wire core_sample, core_convert;
  wire [6:0] positive_input_select, negative_input_select;
  wire [11:0] core_result;
  integer mismatches = 0, comparisons = 0;
  integer pre_cyc = 0, samp_cyc = 0, conv_cyc = 0;

  acs_sequencer dut (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata_r(rdata_r), .start_event(start_event),
    .global_int_en(global_int_en), .irq(irq),
    .result_ready_event_r(result_ready_event_r),
    .positive_input_select(positive_input_select),
    .negative_input_select(negative_input_select),
    .core_differential(core_differential), .core_clk(core_clk),
    .core_sample(core_sample), .core_convert(core_convert),
    .core_result(core_result));
  acs_core_model u_core (.clock(clock), .nrst(nrst),
    .core_convert(core_convert), .core_differential(core_differential),
    .positive_input_select(positive_input_select),
    .core_result(core_result));

  // 40 MHz peripheral clock
  always #12.5 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////
  // Comparison, bus and wait helpers
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [15:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    chk(rdata_r, e);
  endtask
  // Bounded wait: a missing pulse shows up as a failed compare.
  // Phase lengths are tallied on the way for the timing checks.
  task automatic wait_done;
    integer n;
    n = 0;
    pre_cyc = 0;
    samp_cyc = 0;
    conv_cyc = 0;
    do begin
      @(negedge clock);
      n++;
      if (core_sample === 1'b1) samp_cyc++;
      else if (core_convert === 1'b1) conv_cyc++;
      else if (samp_cyc == 0) pre_cyc++;
    end while (result_ready_event_r !== 1'b1 && n < 3000);
    chk(result_ready_event_r, 1'b1);
  endtask
  task automatic quiet(input integer cyc);
    integer n;
    n = 0;
    repeat (cyc) begin
      @(negedge clock);
      if (result_ready_event_r !== 1'b0) n++;
    end
    chk(n, 0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_single;
    wreg(`ACS_OFF_MUX, 16'h0305);
    wreg(`ACS_OFF_CTRLA, 16'h0001);
    wreg(`ACS_OFF_COMMAND, 16'h0001);
    @(negedge clock);
    chk(core_sample, 1'b0);
    @(negedge clock);
    chk(core_sample, 1'b1);
    wreg(`ACS_OFF_MUX, 16'h0409);
    rreg(`ACS_OFF_COMMAND, 16'h0001);
    chk(negative_input_select, 7'h03);
    wait_done;
    rreg(`ACS_OFF_RES, 16'h0085);
    rreg(`ACS_OFF_COMMAND, 16'h0000);
    rreg(`ACS_OFF_INTFLAGS, 16'h0001);
    chk(irq, 1'b0);
    wreg(`ACS_OFF_INTCTRL, 16'h0001);
    @(negedge clock);
    chk(irq, 1'b1);
    @(posedge clock);
    global_int_en <= 1'b0;
    @(negedge clock);
    chk(irq, 1'b0);
    @(posedge clock);
    global_int_en <= 1'b1;
    wreg(`ACS_OFF_INTFLAGS, 16'h0001);
    rreg(`ACS_OFF_INTFLAGS, 16'h0000);
  endtask

  // Plain, ten-bit, left-aligned and differential, then a slow prescaler
  task automatic t_formats;
    logic [15:0] ca [4] = '{16'h0001, 16'h0009, 16'h0005, 16'h0011};
    logic [15:0] ex [4] = '{16'h0089, 16'h0022, 16'h0890, 16'hf809};
    for (int i = 0; i < 4; i++) begin
      wreg(`ACS_OFF_CTRLA, ca[i]);
      wreg(`ACS_OFF_COMMAND, 16'h0001);
      wait_done;
      rreg(`ACS_OFF_RES, ex[i]);
      chk(pre_cyc, 1);
      chk(samp_cyc, 4);
      chk(conv_cyc, 27);
    end
    wreg(`ACS_OFF_CTRLA, 16'h0001);
    wreg(`ACS_OFF_CTRLC, 16'h0002);
    wreg(`ACS_OFF_COMMAND, 16'h0001);
    wait_done;
    rreg(`ACS_OFF_RES, 16'h0089);
    chk(core_clk, 1'b0);
    chk(samp_cyc, 16);
    chk(conv_cyc, 108);
    chk(negative_input_select, 7'h04);
    wreg(`ACS_OFF_CTRLC, 16'h0000);
  endtask

  // Two runs of four samples: the second must not carry the first sum
  task automatic t_accum;
    wreg(`ACS_OFF_CTRLB, 16'h0002);
    repeat (2) begin
      wreg(`ACS_OFF_COMMAND, 16'h0001);
      repeat (50) @(posedge clock);
      rreg(`ACS_OFF_COMMAND, 16'h0001);
      wait_done;
      rreg(`ACS_OFF_RES, 16'h0224);
    end
    wreg(`ACS_OFF_CTRLB, 16'h0000);
  endtask

  // Event edge starts once; a held level and a disabled block do nothing
  task automatic t_event;
    wreg(`ACS_OFF_EVCTRL, 16'h0001);
    start_event <= 1'b1;
    rreg(`ACS_OFF_COMMAND, 16'h0001);
    wait_done;
    quiet(200);
    @(posedge clock);
    start_event <= 1'b0;
    wreg(`ACS_OFF_CTRLA, 16'h0000);
    start_event <= 1'b1;
    wreg(`ACS_OFF_COMMAND, 16'h0001);
    rreg(`ACS_OFF_COMMAND, 16'h0000);
    quiet(100);
    @(posedge clock);
    start_event <= 1'b0;
    wreg(`ACS_OFF_EVCTRL, 16'h0000);
  endtask

  // Warm-up runs once per enable; sampling stretched by delay and length
  task automatic t_warmup;
    wreg(`ACS_OFF_CTRLD, 16'h0103);
    wreg(`ACS_OFF_SAMPCTRL, 16'h0002);
    wreg(`ACS_OFF_CTRLA, 16'h0001);
    wreg(`ACS_OFF_COMMAND, 16'h0001);
    wait_done;
    chk(pre_cyc, 7);
    chk(samp_cyc, 10);
    wreg(`ACS_OFF_COMMAND, 16'h0001);
    wait_done;
    chk(pre_cyc, 1);
    chk(samp_cyc, 10);
    wreg(`ACS_OFF_CTRLD, 16'h0000);
    wreg(`ACS_OFF_SAMPCTRL, 16'h0000);
  endtask

  // Continuous runs, left the safe way before settings change
  task automatic t_continuous_run_en;
    wreg(`ACS_OFF_CTRLA, 16'h0003);
    wreg(`ACS_OFF_COMMAND, 16'h0001);
    wait_done;
    wait_done;
    rreg(`ACS_OFF_COMMAND, 16'h0001);
    wreg(`ACS_OFF_CTRLA, 16'h0001);
    wait_done;
    rreg(`ACS_OFF_COMMAND, 16'h0000);
    quiet(100);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Verdict and sequencing
  task automatic report_and_stop;
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    t_single;
    t_formats;
    t_accum;
    t_event;
    t_warmup;
    t_continuous_run_en;
    report_and_stop;
  end

  // Whole run needs under two thousand cycles; this is a generous margin
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    report_and_stop;
  end
endmodule // acs_sequencer_bench
